// file: common/phy_regmap_pkg.sv
// constants, types and field layout for the phy register map block
package phy_regmap_pkg;

  localparam int ADDR_W    = 11;
  localparam int DATA_W    = 16;
  localparam int MAX_PORTS = 4;
  localparam int SYNC_LEN  = 3;
  localparam int GLB_LAT_W = 5;
  localparam int PRT_LAT_W = 8;
  localparam int CNT_W     = 16;

  // ------------------------------------------------------------
  // global block
  // ------------------------------------------------------------
  localparam logic [10:0] CHIP_IDENTITY_OFS      = 11'h000;
  localparam logic [10:0] GLOBAL_CONTROL_ONE_OFS = 11'h002;
  localparam logic [10:0] GLOBAL_STATUS_OFS      = 11'h014;
  localparam logic [10:0] GLOBAL_LATCHED_OFS     = 11'h016;
  localparam logic [5:0]  GLOBAL_BLOCK_TAG       = 6'h00;
  localparam logic [6:0]  SYSBUS_BLOCK_TAG       = 7'h03;

  localparam logic [15:0] CHIP_IDENTITY_VALUE    = 16'h5a01; // arbitrary value
  localparam logic [15:0] CR1_RESET              = 16'h0000;
  localparam logic [15:0] CR1_ASSIGNED_MASK      = 16'hefff;
  localparam int          CR1_DP_RESET_BIT       = 1;
  localparam int          CR1_LATCH_CLEAR_BIT    = 2;
  localparam int          CR1_UPDATE_BIT         = 3;

  // ------------------------------------------------------------
  // per-port block, offsets relative to the port base
  // ------------------------------------------------------------
  localparam logic [8:0]  PORT_REL_FIRST         = 9'h040;
  localparam logic [8:0]  PORT_CONFIG_OFS        = 9'h040;
  localparam logic [8:0]  PORT_LATCHED_OFS       = 9'h044;
  localparam logic [8:0]  PORT_COUNTER_OFS       = 9'h050;
  localparam logic [15:0] PORT_CONFIG_RESET      = 16'hff01;
  localparam int          PCFG_COUNT_ACTIVE_BIT  = 0;
  localparam int          PCFG_LATCH_EN_LSB      = 8;

  typedef struct packed {
    logic              cs_n;
    logic              rd_n;
    logic              wr_n;
    logic              bus8;
    logic              dp_rst_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } host_pins_t;

  typedef enum logic [1:0] {
    UPD_IDLE = 2'b00,
    UPD_LOAD = 2'b01,
    UPD_DONE = 2'b10
  } upd_state_t;

endpackage

// file: hw/latched_status.sv
// bank of latched status bits with edge-qualified set and masked clear
`timescale 1ns/1ns
`default_nettype none
module latched_status #(
  parameter int          WIDTH     = 8,
  parameter logic [WIDTH-1:0] ON_CHANGE = '0
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_event,
  input  wire logic [WIDTH-1:0] i_enable,
  input  wire logic [WIDTH-1:0] i_clear,
  input  wire logic             i_flush,
  output logic      [WIDTH-1:0] o_latched
);

  logic [WIDTH-1:0] event_prev_q;
  logic [WIDTH-1:0] set_w;
  logic [WIDTH-1:0] latched_d;

  // a held event cannot re-set a cleared bit; only a fresh edge does
  assign set_w     = i_enable & ((i_event & ~event_prev_q) |
                                 (ON_CHANGE & ~i_event & event_prev_q));
  // set beats clear in the same cycle so no event is lost
  assign latched_d = i_flush ? '0 : (set_w | (o_latched & ~i_clear));

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      event_prev_q <= '0;
      o_latched    <= '0;
    end else begin
      event_prev_q <= i_event;
      o_latched    <= latched_d;
    end
  end

endmodule
`default_nettype wire

// file: hw/sat_counter.sv
// saturating event counter with snapshot register and zero indication
`timescale 1ns/1ns
`default_nettype none
module sat_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic             i_event,
  input  wire logic             i_active,
  input  wire logic             i_load,
  input  wire logic             i_flush,
  output logic      [WIDTH-1:0] o_count_reg,
  output logic                  o_zero
);

  logic [WIDTH-1:0] live_q;
  logic [WIDTH-1:0] live_d;
  logic [WIDTH-1:0] reg_d;
  logic             inc_w;

  // an inactive counter keeps its value but never counts
  assign inc_w  = i_event & i_active;
  // on load the event of that cycle becomes the first new count
  assign live_d = i_flush ? '0 :
                  i_load  ? {{(WIDTH-1){1'b0}}, inc_w} :
                  (inc_w && live_q != '1) ? live_q + WIDTH'(1'b1) : live_q;
  assign reg_d  = i_flush ? '0 : (i_load ? live_q : o_count_reg);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      live_q      <= '0;
      o_count_reg <= '0;
      o_zero      <= 1'b1;
    end else begin
      live_q      <= live_d;
      o_count_reg <= reg_d;
      o_zero      <= ~i_load & (reg_d == '0);
    end
  end

endmodule
`default_nettype wire

// file: hw/phy_regmap_top.sv
// host register bus, address decode and global/per-port register banks
`timescale 1ns/1ns
`default_nettype none
module phy_regmap_top #(
  parameter int          NUM_PORTS   = 4,
  parameter logic [15:0] IDENT_VALUE = phy_regmap_pkg::CHIP_IDENTITY_VALUE
) (
  input  wire logic                                   i_sys_clk,
  input  wire logic                                   i_rst,
  input  wire logic                                   i_cs_n,
  input  wire logic                                   i_rd_n,
  input  wire logic                                   i_wr_n,
  input  wire logic                                   i_bus8_mode,
  input  wire logic [phy_regmap_pkg::ADDR_W-1:0]      i_addr,
  input  wire logic [phy_regmap_pkg::DATA_W-1:0]      i_data,
  input  wire logic                                   i_datapath_reset_n,
  input  wire logic [phy_regmap_pkg::GLB_LAT_W-2:0]   i_global_event,
  input  wire logic [phy_regmap_pkg::MAX_PORTS*phy_regmap_pkg::PRT_LAT_W-1:0] i_port_event,
  input  wire logic [phy_regmap_pkg::MAX_PORTS-1:0]   i_count_event,
  output logic      [phy_regmap_pkg::DATA_W-1:0]      o_data,
  output logic                                        o_data_oe,
  output logic                                        o_rdy_n,
  output logic                                        o_update_status,
  output logic      [phy_regmap_pkg::MAX_PORTS-1:0]   o_zero_count
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [1:0]  be);
    merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // ------------------------------------------------------------
  // pin synchroniser: three stages, a bit moves once 2 and 3 agree
  // ------------------------------------------------------------
  phy_regmap_pkg::host_pins_t pins_w;
  phy_regmap_pkg::host_pins_t sync1_q;
  phy_regmap_pkg::host_pins_t sync2_q;
  phy_regmap_pkg::host_pins_t sync3_q;
  phy_regmap_pkg::host_pins_t pins_q;
  phy_regmap_pkg::host_pins_t pins_d;

  assign pins_w = '{cs_n: i_cs_n, rd_n: i_rd_n, wr_n: i_wr_n, bus8: i_bus8_mode,
                    dp_rst_n: i_datapath_reset_n, addr: i_addr, data: i_data};
  assign pins_d = (sync2_q & sync3_q) | (pins_q & (sync2_q | sync3_q));

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= '1;
      sync2_q <= '1;
      sync3_q <= '1;
      pins_q  <= '1;
    end else begin
      sync1_q <= pins_w;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pins_q  <= pins_d;
    end
  end

  // ------------------------------------------------------------
  // access detection
  // ------------------------------------------------------------
  logic active_w;
  logic active_prev_q;
  logic start_w;
  logic rd_go_w;
  logic wr_go_w;

  assign active_w = ~pins_q.cs_n & (~pins_q.rd_n | ~pins_q.wr_n);
  assign start_w  = active_w & ~active_prev_q;
  assign rd_go_w  = start_w & ~pins_q.rd_n;
  assign wr_go_w  = start_w & ~pins_q.wr_n & pins_q.rd_n;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic [10:0] addr_w;
  logic [10:0] word_w;
  logic [1:0]  port_w;
  logic [8:0]  rel_w;
  logic        hi_byte_w;
  logic [1:0]  be_w;
  logic [15:0] wdata_w;
  logic        in_global_w;
  logic        in_sysbus_w;
  logic        in_test_w;
  logic        in_port_w;
  logic        mapped_w;

  assign addr_w      = {(NUM_PORTS > 2) ? pins_q.addr[10] : 1'b0, pins_q.addr[9:0]};
  assign word_w      = {addr_w[10:1], 1'b0};
  assign port_w      = word_w[10:9];
  assign rel_w       = word_w[8:0];
  assign hi_byte_w   = pins_q.bus8 & addr_w[0];
  assign be_w        = pins_q.bus8 ? {hi_byte_w, ~hi_byte_w} : 2'b11;
  assign wdata_w     = pins_q.bus8 ? {pins_q.data[7:0], pins_q.data[7:0]} : pins_q.data;
  assign in_global_w = word_w[10:5] == phy_regmap_pkg::GLOBAL_BLOCK_TAG;
  assign in_sysbus_w = word_w[10:4] == phy_regmap_pkg::SYSBUS_BLOCK_TAG;
  assign in_test_w   = (rel_w < phy_regmap_pkg::PORT_REL_FIRST) &&
                       (port_w == 2'd1 || port_w == 2'd2);
  assign in_port_w   = (rel_w >= phy_regmap_pkg::PORT_REL_FIRST) &&
                       (32'(port_w) < NUM_PORTS);
  // holes outside every block and absent port register ranges get no ready strobe; with two ports or fewer ports 2-3 alias onto 0-1
  assign mapped_w    = in_global_w | in_sysbus_w | in_test_w | in_port_w;

  logic hit_cr1_w;
  logic hit_glat_w;
  logic hit_pcfg_w;
  logic hit_plat_w;

  assign hit_cr1_w  = word_w == phy_regmap_pkg::GLOBAL_CONTROL_ONE_OFS;
  assign hit_glat_w = word_w == phy_regmap_pkg::GLOBAL_LATCHED_OFS;
  assign hit_pcfg_w = in_port_w && rel_w == phy_regmap_pkg::PORT_CONFIG_OFS;
  assign hit_plat_w = in_port_w && rel_w == phy_regmap_pkg::PORT_LATCHED_OFS;

  // ------------------------------------------------------------
  // configuration registers and their effective copies
  // ------------------------------------------------------------
  logic [15:0] cr1_q;
  logic [15:0] cr1_eff_q;
  logic [15:0] pcfg_q     [phy_regmap_pkg::MAX_PORTS];
  logic [15:0] pcfg_eff_q [phy_regmap_pkg::MAX_PORTS];
  logic        dp_reset_w;
  logic        clear_on_read_w;

  assign dp_reset_w      = ~pins_q.dp_rst_n | cr1_q[phy_regmap_pkg::CR1_DP_RESET_BIT];
  assign clear_on_read_w = cr1_eff_q[phy_regmap_pkg::CR1_LATCH_CLEAR_BIT];

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cr1_q     <= phy_regmap_pkg::CR1_RESET;
      cr1_eff_q <= phy_regmap_pkg::CR1_RESET;
      for (int p = 0; p < phy_regmap_pkg::MAX_PORTS; p++) begin
        pcfg_q[p]     <= phy_regmap_pkg::PORT_CONFIG_RESET;
        pcfg_eff_q[p] <= phy_regmap_pkg::PORT_CONFIG_RESET;
      end
    end else begin
      // unassigned bits are dropped here so they always read zero
      if (wr_go_w && hit_cr1_w) begin
        cr1_q <= merge(cr1_q, wdata_w, be_w) & phy_regmap_pkg::CR1_ASSIGNED_MASK;
      end
      // the stored value stays readable; the block only sees it after release
      if (!dp_reset_w) begin
        cr1_eff_q <= cr1_q;
      end
      for (int p = 0; p < phy_regmap_pkg::MAX_PORTS; p++) begin
        if (wr_go_w && hit_pcfg_w && 32'(port_w) == p) begin
          pcfg_q[p] <= merge(pcfg_q[p], wdata_w, be_w);
        end
        if (!dp_reset_w) begin
          pcfg_eff_q[p] <= pcfg_q[p];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // counter update sequencer
  // ------------------------------------------------------------
  phy_regmap_pkg::upd_state_t upd_q;
  phy_regmap_pkg::upd_state_t upd_d;
  logic                       upd_prev_q;
  logic                       upd_edge_w;
  logic                       load_w;

  // during datapath reset the edge tracker follows the raw bit, so a
  // rising edge written then is consumed and must be written again
  assign upd_edge_w = cr1_q[phy_regmap_pkg::CR1_UPDATE_BIT] & ~upd_prev_q & ~dp_reset_w;
  // load on the starting edge so the zero pulse is over as update status rises
  assign load_w     = upd_edge_w & (upd_q == phy_regmap_pkg::UPD_IDLE);

  always_comb begin
    case (upd_q)
      phy_regmap_pkg::UPD_IDLE: begin
        upd_d = upd_edge_w ? phy_regmap_pkg::UPD_LOAD : phy_regmap_pkg::UPD_IDLE;
      end
      phy_regmap_pkg::UPD_LOAD: begin
        upd_d = phy_regmap_pkg::UPD_DONE;
      end
      phy_regmap_pkg::UPD_DONE: begin
        upd_d = phy_regmap_pkg::UPD_IDLE;
      end
      default: begin
        upd_d = phy_regmap_pkg::UPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      upd_q           <= phy_regmap_pkg::UPD_IDLE;
      upd_prev_q      <= 1'b0;
      o_update_status <= 1'b0;
    end else begin
      upd_q      <= upd_d;
      upd_prev_q <= cr1_q[phy_regmap_pkg::CR1_UPDATE_BIT];
      if (upd_edge_w && upd_q == phy_regmap_pkg::UPD_IDLE) begin
        o_update_status <= 1'b0;
      end else if (upd_q == phy_regmap_pkg::UPD_DONE) begin
        o_update_status <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // latched status clearing
  // ------------------------------------------------------------
  logic [15:0] rd_clear_w;
  logic [15:0] wr_clear_w;

  // clear-on-read takes the whole word in 16-bit mode, the byte otherwise
  assign rd_clear_w = (rd_go_w && clear_on_read_w) ? lane_mask(be_w) : 16'h0000;
  assign wr_clear_w = (wr_go_w && !clear_on_read_w) ? (wdata_w & lane_mask(be_w)) : 16'h0000;

  logic [phy_regmap_pkg::GLB_LAT_W-1:0] glat_w;
  logic [phy_regmap_pkg::GLB_LAT_W-1:0] glat_clr_w;

  assign glat_clr_w = hit_glat_w ? rd_clear_w[phy_regmap_pkg::GLB_LAT_W-1:0] |
                                   wr_clear_w[phy_regmap_pkg::GLB_LAT_W-1:0] : '0;

  // bit 0 follows the update status on both edges
  latched_status #(
    .WIDTH     (phy_regmap_pkg::GLB_LAT_W),
    .ON_CHANGE (5'h01)
  ) u_global_latched (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_event   ({i_global_event, o_update_status}),
    .i_enable  ('1),
    .i_clear   (glat_clr_w),
    .i_flush   (dp_reset_w),
    .o_latched (glat_w)
  );

  // ------------------------------------------------------------
  // per-port latched bits and counters
  // ------------------------------------------------------------
  logic [phy_regmap_pkg::PRT_LAT_W-1:0] plat_w [phy_regmap_pkg::MAX_PORTS];
  logic [phy_regmap_pkg::CNT_W-1:0]     pcnt_w [phy_regmap_pkg::MAX_PORTS];
  logic [phy_regmap_pkg::MAX_PORTS-1:0] zero_w;

  for (genvar p = 0; p < phy_regmap_pkg::MAX_PORTS; p++) begin : g_port
    if (p < NUM_PORTS) begin : g_present
      logic [phy_regmap_pkg::PRT_LAT_W-1:0] clr_w;

      assign clr_w = (hit_plat_w && 32'(port_w) == p) ?
                     rd_clear_w[phy_regmap_pkg::PRT_LAT_W-1:0] |
                     wr_clear_w[phy_regmap_pkg::PRT_LAT_W-1:0] : '0;

      // disabled positions act reserved: they hold but never newly set
      latched_status #(
        .WIDTH     (phy_regmap_pkg::PRT_LAT_W),
        .ON_CHANGE ('0)
      ) u_latched (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_event   (i_port_event[p*phy_regmap_pkg::PRT_LAT_W +: phy_regmap_pkg::PRT_LAT_W]),
        .i_enable  (pcfg_eff_q[p][phy_regmap_pkg::PCFG_LATCH_EN_LSB +: phy_regmap_pkg::PRT_LAT_W]),
        .i_clear   (clr_w),
        .i_flush   (dp_reset_w),
        .o_latched (plat_w[p])
      );

      sat_counter #(
        .WIDTH (phy_regmap_pkg::CNT_W)
      ) u_counter (
        .i_sys_clk   (i_sys_clk),
        .i_rst       (i_rst),
        .i_event     (i_count_event[p]),
        .i_active    (pcfg_eff_q[p][phy_regmap_pkg::PCFG_COUNT_ACTIVE_BIT]),
        .i_load      (load_w),
        .i_flush     (dp_reset_w),
        .o_count_reg (pcnt_w[p]),
        .o_zero      (zero_w[p])
      );
    end else begin : g_absent
      assign plat_w[p] = '0;
      assign pcnt_w[p] = '0;
      assign zero_w[p] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // read mux; anything not listed (reserved, unused, test) reads zero
  // ------------------------------------------------------------
  logic [15:0] rdata_w;
  logic [15:0] port_rdata_w;
  logic [15:0] glob_rdata_w;
  logic [15:0] byte_rdata_w;

  assign port_rdata_w = (rel_w == phy_regmap_pkg::PORT_CONFIG_OFS)  ? pcfg_q[port_w] :
                        (rel_w == phy_regmap_pkg::PORT_LATCHED_OFS) ? {8'h00, plat_w[port_w]} :
                        (rel_w == phy_regmap_pkg::PORT_COUNTER_OFS) ? pcnt_w[port_w] : 16'h0000;
  assign glob_rdata_w = (word_w == phy_regmap_pkg::CHIP_IDENTITY_OFS)  ? IDENT_VALUE :
                        hit_cr1_w                                      ? cr1_q :
                        (word_w == phy_regmap_pkg::GLOBAL_STATUS_OFS)  ? {15'h0000, o_update_status} :
                        hit_glat_w                                     ? {11'h000, glat_w} : 16'h0000;
  assign rdata_w      = in_port_w ? port_rdata_w : (in_global_w ? glob_rdata_w : 16'h0000);
  assign byte_rdata_w = pins_q.bus8 ? {8'h00, hi_byte_w ? rdata_w[15:8] : rdata_w[7:0]} : rdata_w;

  // ------------------------------------------------------------
  // bus handshake: ready stays low until the strobe goes away
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      active_prev_q <= 1'b0;
      o_rdy_n       <= 1'b1;
      o_data        <= 16'h0000;
      o_data_oe     <= 1'b0;
      o_zero_count  <= '1;
    end else begin
      active_prev_q <= active_w;
      o_zero_count  <= zero_w;
      if (!active_w) begin
        o_rdy_n   <= 1'b1;
        o_data_oe <= 1'b0;
      end else if (start_w) begin
        o_rdy_n   <= ~mapped_w;
        o_data_oe <= rd_go_w & mapped_w;
        if (rd_go_w) begin
          o_data <= byte_rdata_w;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: verification/phy_regmap_assertions.sv
// concurrent checks on the host bus and counter update outputs
`timescale 1ns/1ns
`default_nettype none
module phy_regmap_checker (
  input wire logic                                 i_sys_clk,
  input wire logic                                 i_rst,
  input wire logic                                 i_cs_n,
  input wire logic                                 i_rd_n,
  input wire logic                                 i_wr_n,
  input wire logic                                 o_rdy_n,
  input wire logic                                 o_data_oe,
  input wire logic                                 o_update_status,
  input wire logic [phy_regmap_pkg::MAX_PORTS-1:0] o_zero_count
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  chk_rdy_needs_strobe: assert property ($fell(o_rdy_n) |-> !i_cs_n && !(i_rd_n && i_wr_n))
    else $error("ready without a strobe");
  chk_rdy_holds: assert property ($fell(o_rdy_n) |=> !o_rdy_n[*2])
    else $error("ready dropped early");
  chk_rdy_idle: assert property (i_cs_n[*7] |-> o_rdy_n)
    else $error("ready while deselected");
  chk_oe_on_read: assert property ($rose(o_data_oe) |-> !i_rd_n && !i_cs_n)
    else $error("bus driven without read");
  chk_oe_idle: assert property (i_cs_n[*7] |-> !o_data_oe)
    else $error("bus driven while deselected");
  chk_zero_in_upd: assert property ($fell(o_zero_count[0]) |-> !o_update_status)
    else $error("zero pulse outside update");
  chk_status_low: assert property ($fell(o_update_status) |=> !o_update_status)
    else $error("update status back too soon");
  chk_zero_then_done: assert property ($fell(o_zero_count[0]) |-> ##[1:3] o_update_status)
    else $error("update status missing");
  chk_upd_zero: assert property ($fell(o_update_status) |-> ##[1:4] !o_zero_count[0])
    else $error("no zero pulse in update");
endmodule
bind phy_regmap_top phy_regmap_checker chk (.i_sys_clk, .i_rst, .i_cs_n, .i_rd_n, .i_wr_n,
  .o_rdy_n, .o_data_oe, .o_update_status, .o_zero_count);
`default_nettype wire

// file: verification/host_bus_model.sv
// host processor model driving the asynchronous register bus pins
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rdy_n,
  input  wire logic [15:0] i_data,
  output logic             o_cs_n,
  output logic             o_rd_n,
  output logic             o_wr_n,
  output logic [10:0]      o_addr,
  output logic [15:0]      o_data
);
  initial {o_cs_n, o_rd_n, o_wr_n, o_addr, o_data} = {3'h7, 11'h000, 16'h0000};
  // strobe held until ready is sampled low; gives up after 16 edges
  task automatic acc(input logic wr, input logic [10:0] a, input logic [15:0] d,
                     output logic [15:0] q, output logic ok);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    o_addr = a;
    o_data = d;
    {o_cs_n, o_rd_n, o_wr_n} = {1'b0, wr, !wr};
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (i_rdy_n !== 1'b0 && n < 16);
    ok = (i_rdy_n === 1'b0);
    q = i_data;
    @(negedge i_sys_clk);
    {o_cs_n, o_rd_n, o_wr_n} = 3'h7;
    // released bus must not keep showing the old value
    o_data = ~d;
    // strobe filter needs a few clocks of idle before the next access
    repeat (10) @(negedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

// file: verification/test_phy_register_map_access.sv
// self-checking bench for the register map block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; $display("BAD %0t got %h want %h", $time, a, e); end end
module test_phy_register_map_access;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        bus8 = 1'b0;
  logic        dp_n = 1'b1;
  logic        cs_n, rd_n, wr_n, rdy_n, oe, upd, ok;
  logic [10:0] addr;
  logic [15:0] wd, rdat, q;
  logic [31:0] pev = '0;
  logic [3:0]  cev = '0;
  logic [3:0]  zero;
  int          bad_count = 0;
  int          n_compared = 0;
  localparam logic [15:0] ID = phy_regmap_pkg::CHIP_IDENTITY_VALUE;
  localparam logic [15:0] PCR = phy_regmap_pkg::PORT_CONFIG_RESET;
  always #50 clk = ~clk;
  phy_regmap_top dut (.i_sys_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_bus8_mode(bus8), .i_addr(addr), .i_data(wd), .i_datapath_reset_n(dp_n), .i_global_event(4'h0),
    .i_port_event(pev), .i_count_event(cev), .o_data(rdat), .o_data_oe(oe), .o_rdy_n(rdy_n),
    .o_update_status(upd), .o_zero_count(zero));
  host_bus_model host (.i_sys_clk(clk), .i_rdy_n(rdy_n), .i_data(rdat), .o_cs_n(cs_n),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr), .o_data(wd));
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    host.acc(1'b1, a, d, q, ok);
  endtask
  task automatic rc(input logic [10:0] a, input logic [15:0] e);
    host.acc(1'b0, a, 16'h0000, q, ok);
    `CHK({ok, q}, {1'b1, e})
  endtask
  task automatic ev(input int n);
    repeat (n) begin
      @(negedge clk) pev[0] = ~pev[0];
      repeat (4) @(negedge clk);
    end
  endtask
  task automatic count(input int n);
    repeat (n) begin
      @(negedge clk) cev = 4'h1;
      @(negedge clk) cev = 4'h0;
    end
    wr(11'h002, 16'h0008);
    wr(11'h002, 16'h0000);
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rc(11'h000, ID);
    rc(11'h002, phy_regmap_pkg::CR1_RESET);
    rc(11'h040, PCR);
    wr(11'h000, 16'h0000);
    rc(11'h000, ID);
    wr(11'h002, 16'hefd1);
    rc(11'h002, 16'hefd1);
    rc(11'h200, 16'h0000);
    host.acc(1'b0, 11'h620, 16'h0000, q, ok);
    `CHK(ok, 1'b0)
    wr(11'h640, 16'h0001);
    rc(11'h640, 16'h0001);
    rc(11'h240, PCR);
    rc(11'h440, PCR);
    bus8 = 1'b1;
    rc(11'h001, {8'h00, ID[15:8]});
    rc(11'h000, {8'h00, ID[7:0]});
    bus8 = 1'b0;
    ev(1);
    rc(11'h044, 16'h0001);
    wr(11'h044, 16'h0000);
    rc(11'h044, 16'h0001);
    wr(11'h044, 16'h0001);
    rc(11'h044, 16'h0000);
    wr(11'h002, 16'h0004);
    ev(2);
    bus8 = 1'b1;
    rc(11'h045, 16'h0000);
    rc(11'h044, 16'h0001);
    rc(11'h044, 16'h0000);
    bus8 = 1'b0;
    ev(2);
    dp_n = 1'b0;
    wr(11'h002, 16'h000c);
    dp_n = 1'b1;
    rc(11'h044, 16'h0000);
    `CHK(upd, 1'b0)
    wr(11'h002, 16'h0004);
    count(5);
    rc(11'h050, 16'h0005);
    `CHK({upd, zero[0], oe}, 3'b100)
    count(0);
    rc(11'h050, 16'h0000);
    `CHK(zero[0], 1'b1)
    wr(11'h040, 16'hff00);
    count(3);
    rc(11'h050, 16'h0000);
    end_sim();
  end
  initial begin
    #600000;
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
